// File: logic/adcslp_top.sv
// Converter sleep, start delay, completion and reset control
`timescale 1ns/1ps
`include "adcslp_defines.svh"
// Operation
// - Conversion continues in sleep only with RC
// - RC clock delays start one instruction cycle
// - Completion clears start flag, stores result
// - Enabled interrupt completion wakes from sleep
// - Disabled interrupt: no wake, power bit stays
// - Non-RC sleep aborts, powers down, bit stays
// - Shut-down converter takes lowest current state
// - Reset clears registers, powers off, aborts
// - Result register untouched by power-on reset
module adcslp_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire adcslp_pkg::adcslp_bus_req_t bus,
  output logic [7:0] rdata,
  input wire logic sleep_exec,
  input wire logic [7:0] sample_in,
  output logic sample_en,
  output logic analog_power_en,
  output logic wake,
  output logic irq
);
  adcslp_pkg::adcslp_state_t state_r;
  adcslp_pkg::adcslp_state_t state_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] mask_r;
  logic [1:0] mask_nxt;
  logic asleep_r;
  logic asleep_nxt;
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic [3:0] bits_r;
  logic [3:0] bits_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] icyc_r;
  logic [1:0] icyc_nxt;
  logic tick;
  logic done;
  logic abort;
  logic rc_sel;
  logic [7:0] result;
  logic wr_ctrl;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  assign rc_sel = ctrl_r[`ADCSLP_CTRL_CLKSEL_HI:`ADCSLP_CTRL_CLKSEL_LO]
    == `ADCSLP_CLKSEL_RC;
  assign wr_ctrl = bus.wr && hit(bus.addr, `ADCSLP_ADDR_CTRL);

  // Counted from entry, so the delay spans a whole instruction cycle
  always_comb
  begin
    icyc_nxt = 2'h0;
    if (state_r == adcslp_pkg::ST_DELAY && icyc_r != `ADCSLP_INSTR_DIV)
    begin
      icyc_nxt = icyc_r + 2'h1;
    end
  end

  // Bit-time enable: RC runs slower and also runs in sleep
  always_comb
  begin
    div_nxt = div_r + 4'h1;
    tick = 1'b0;
    if (state_r != adcslp_pkg::ST_CONV)
    begin
      div_nxt = 4'h0;
    end
    else if (rc_sel ? (div_r == `ADCSLP_RC_DIV)
                    : (div_r[1:0] == `ADCSLP_OSC_DIV))
    begin
      div_nxt = 4'h0;
      tick = 1'b1;
    end
  end

  // Core state machine
  always_comb
  begin
    state_nxt = state_r;
    bits_nxt = bits_r;
    done = 1'b0;
    abort = 1'b0;
    case (state_r)
      adcslp_pkg::ST_OFF:
      begin
        if (ctrl_r[`ADCSLP_CTRL_POWER_BIT])
        begin
          state_nxt = adcslp_pkg::ST_IDLE;
        end
      end
      adcslp_pkg::ST_IDLE:
      begin
        if (!ctrl_r[`ADCSLP_CTRL_POWER_BIT])
        begin
          state_nxt = adcslp_pkg::ST_OFF;
        end
        else if (ctrl_r[`ADCSLP_CTRL_START_BIT])
        begin
          state_nxt = rc_sel ? adcslp_pkg::ST_DELAY : adcslp_pkg::ST_CONV;
          bits_nxt = 4'h0;
        end
      end
      adcslp_pkg::ST_DELAY:
      begin
        if (icyc_r == `ADCSLP_INSTR_DIV)
        begin
          state_nxt = adcslp_pkg::ST_CONV;
        end
      end
      adcslp_pkg::ST_CONV:
      begin
        if (tick)
        begin
          bits_nxt = bits_r + 4'h1;
          if (bits_r == `ADCSLP_NUM_BITS - 4'h1)
          begin
            done = 1'b1;
            state_nxt = adcslp_pkg::ST_IDLE;
          end
        end
      end
      default:
      begin
        state_nxt = adcslp_pkg::ST_OFF;
      end
    endcase
    // Sleep abort and shutdown
    // Also held in the off state, or the power bit would restart it
    if (!rc_sel && (sleep_exec || asleep_r))
    begin
      abort = (state_r == adcslp_pkg::ST_CONV
               || state_r == adcslp_pkg::ST_DELAY);
      done = 1'b0;
      state_nxt = adcslp_pkg::ST_OFF;
    end
    else if (state_r != adcslp_pkg::ST_OFF
             && !ctrl_r[`ADCSLP_CTRL_POWER_BIT])
    begin
      done = 1'b0;
      state_nxt = adcslp_pkg::ST_OFF;
    end
  end

  // Registers: control, status, mask, sleep flag
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    asleep_nxt = asleep_r;
    if (sleep_exec)
    begin
      asleep_nxt = 1'b1;
    end
    if (wake)
    begin
      asleep_nxt = 1'b0;
    end
    if (wr_ctrl)
    begin
      ctrl_nxt = {4'h0, bus.wdata[3:0]};
    end
    if (bus.wr && hit(bus.addr, `ADCSLP_ADDR_MASK))
    begin
      mask_nxt = bus.wdata[1:0];
    end
    if (bus.wr && hit(bus.addr, `ADCSLP_ADDR_STATUS))
    begin
      stat_nxt = stat_r & ~bus.wdata[1:0];
    end
    if (done || abort)
    begin
      ctrl_nxt[`ADCSLP_CTRL_START_BIT] = 1'b0;
    end
    // Set wins over a simultaneous write-one clear
    if (done)
    begin
      stat_nxt[`ADCSLP_IRQ_DONE_BIT] = 1'b1;
    end
    if (abort)
    begin
      stat_nxt[`ADCSLP_IRQ_ABORT_BIT] = 1'b1;
    end
  end

  // Read data one cycle after the strobe
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        `ADCSLP_ADDR_CTRL: rdata_nxt = ctrl_r;
        `ADCSLP_ADDR_RESULT: rdata_nxt = result;
        `ADCSLP_ADDR_STATUS: rdata_nxt = {6'h00, stat_r};
        `ADCSLP_ADDR_MASK: rdata_nxt = {6'h00, mask_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= adcslp_pkg::ST_OFF;
      ctrl_r <= `ADCSLP_CTRL_RESET;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      asleep_r <= 1'b0;
      div_r <= 4'h0;
      bits_r <= 4'h0;
      rdata_r <= 8'h00;
      icyc_r <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      asleep_r <= asleep_nxt;
      div_r <= div_nxt;
      bits_r <= bits_nxt;
      rdata_r <= rdata_nxt;
      icyc_r <= icyc_nxt;
    end
  end

  adcslp_result_reg u_result (
    .ref_clk(ref_clk),
    .load(done),
    .din(sample_in),
    .dout(result)
  );

  assign rdata = rdata_r;
  assign analog_power_en = (state_r != adcslp_pkg::ST_OFF);
  assign sample_en = (state_r == adcslp_pkg::ST_CONV);
  assign irq = |(stat_r & mask_r);
  assign wake = asleep_r && stat_r[`ADCSLP_IRQ_DONE_BIT]
    && mask_r[`ADCSLP_IRQ_DONE_BIT];
endmodule

// File: logic/adcslp_defines.svh
// Offsets, field positions, reset values and timing counts for the converter
`ifndef ADCSLP_DEFINES_SVH
`define ADCSLP_DEFINES_SVH
`define ADCSLP_ADDR_CTRL 4'h0
`define ADCSLP_ADDR_RESULT 4'h1
`define ADCSLP_ADDR_STATUS 4'h2
`define ADCSLP_ADDR_MASK 4'h3
`define ADCSLP_CTRL_POWER_BIT 0
`define ADCSLP_CTRL_START_BIT 1
`define ADCSLP_CTRL_CLKSEL_LO 2
`define ADCSLP_CTRL_CLKSEL_HI 3
`define ADCSLP_CTRL_RESET 8'h00
`define ADCSLP_CLKSEL_RC 2'h3
`define ADCSLP_NUM_BITS 4'h8
`define ADCSLP_INSTR_DIV 2'h3
`define ADCSLP_RC_DIV 4'hF
`define ADCSLP_OSC_DIV 2'h1
`define ADCSLP_IRQ_DONE_BIT 0
`define ADCSLP_IRQ_ABORT_BIT 1
`endif

// File: logic/adcslp_pkg.sv
// Types shared by the converter control logic
package adcslp_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_IDLE,
    ST_DELAY,
    ST_CONV
  } adcslp_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcslp_bus_req_t;
endpackage

// File: logic/adcslp_result_reg.sv
// Result holding register with no power-on initialisation
`timescale 1ns/1ps
module adcslp_result_reg (
  input wire logic ref_clk,
  input wire logic load,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] data_r;
  logic [7:0] data_nxt;

  always_comb
  begin
    data_nxt = load ? din : data_r;
  end

  // Deliberately no reset: contents are unknown after power-on
  always_ff @(posedge ref_clk)
  begin
    data_r <= data_nxt;
  end

  assign dout = data_r;
endmodule

// File: test/adcslp_props.sv
// Port checker for the converter control block
`timescale 1ns/1ps
module adcslp_props (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire adcslp_pkg::adcslp_bus_req_t bus,
  input wire logic [7:0] rdata,
  input wire logic sleep_exec,
  input wire logic sample_en,
  input wire logic analog_power_en,
  input wire logic wake,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_RDATA_IDLE: assert property (
    !$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");
  AST_WAKE_IRQ: assert property (wake |-> irq)
    else $error("wake without unmasked status");
  AST_OFF_IDLE: assert property (sample_en |-> analog_power_en)
    else $error("converting while shut down");
  // Start write outside a conversion only, hence the sample_en guard
  AST_RC_DELAY: assert property (
    bus.wr && bus.addr == 4'h0 && bus.wdata[3:0] == 4'hF && !sample_en
    |=> (!sample_en)[*5])
    else $error("start not delayed");
  AST_CONV_END: assert property (
    $rose(sample_en) |-> ##[1:136] !sample_en)
    else $error("conversion never ends");
  AST_CONV_MIN: assert property (
    $rose(sample_en) ##0 (!sleep_exec)[*7] |=> sample_en)
    else $error("conversion cut short");
  AST_IRQ_HOLD: assert property (irq && !bus.wr |=> irq)
    else $error("status lost without clear");
  AST_IRQ_CAUSE: assert property (
    $rose(irq) |-> $past(sample_en) || $past(bus.wr) || $past(sleep_exec))
    else $error("interrupt without event");
  // A non-RC sleep keeps the converter down for at least four cycles after power falls
  AST_ABORT_OFF: assert property (
    $fell(analog_power_en) && $past(sleep_exec) |=> (!analog_power_en)[*4])
    else $error("converter restarted after sleep abort");
  AST_COV_WAKE: cover property ($rose(wake));
  AST_COV_ABORT: cover property ($fell(analog_power_en));
  AST_COV_DONE: cover property ($fell(sample_en) && !sleep_exec);
endmodule
bind adcslp_top adcslp_props i_props (.ref_clk, .rstn, .bus, .rdata,
  .sleep_exec, .sample_en, .analog_power_en, .wake, .irq);

// File: test/adcslp_core_model.sv
// Core model: executes one sleep instruction per request
`timescale 1ns/1ps
module adcslp_core_model (
  input wire logic ref_clk,
  input wire logic sleep_req,
  output logic sleep_exec
);
  logic q = 1'b0;
  initial sleep_exec = 1'b0;
  always @(posedge ref_clk)
  begin
    sleep_exec <= sleep_req & ~q;
    q <= sleep_req;
  end
endmodule

// File: test/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adcslp_defines.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
  logic ref_clk = 0;
  logic rstn = 0;
  adcslp_pkg::adcslp_bus_req_t bus = '0;
  logic [7:0] rdata, last;
  logic [7:0] sample_in = 8'h00;
  logic [7:0] lfsr = 8'h06;
  logic sleep_req = 0;
  logic sleep_exec, sample_en, analog_power_en, wake, irq;
  int exp_q[$];
  int checks = 0;
  int miscompares = 0;
  always #4 ref_clk = ~ref_clk;
  adcslp_top i_dut (.ref_clk, .rstn, .bus, .rdata, .sleep_exec, .sample_in,
    .sample_en, .analog_power_en, .wake, .irq);
  adcslp_core_model i_core (.ref_clk, .sleep_req, .sleep_exec);
  function automatic logic [7:0] nxt(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic wr(logic [3:0] a, logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk_rd(logic [3:0] a, logic [7:0] e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
    @(posedge ref_clk);
  endtask
  // Mask m, sleep s; a masked sleep leaves the core asleep, so run it last
  task automatic conv(logic m, logic s);
    int cnt;
    lfsr = nxt(lfsr);
    sample_in <= lfsr;
    exp_q.push_back(lfsr);
    wr(4'h3, {7'h00, m});
    // RC selected for every sleeping conversion
    sleep_req <= s;
    wr(4'h0, 8'h0F);
    sleep_req <= 1'b0;
    for (cnt = 0; cnt < 20 && !sample_en; cnt++)
    begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("rc delay", 1'b1, cnt >= `ADCSLP_INSTR_DIV + 1)
    for (cnt = 0; cnt < 300 && sample_en; cnt++)
    begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("conv len", `ADCSLP_NUM_BITS * (`ADCSLP_RC_DIV + 1), cnt)
    `CHK("wake", m & s, wake)
    `CHK("irq", m, irq)
    chk_rd(4'h0, 8'h0D);
    last = 8'(exp_q.pop_front());
    chk_rd(4'h1, last);
    chk_rd(4'h2, 8'h01);
    wr(4'h2, 8'h01);
    #1 `CHK("irq", 1'b0, irq)
    $display("conv test done");
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    miscompares++;
    results();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk_rd(4'h0, 8'h00);
    chk_rd(4'h2, 8'h00);
    chk_rd(4'h7, 8'h00);
    for (int k = 0; k < 3; k++) conv(k < 2, k > 0);
    // Reset also lifts the core out of the masked sleep
    wr(4'h3, 8'h03);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1 `CHK("power", 1'b0, analog_power_en)
    chk_rd(4'h0, 8'h00);
    chk_rd(4'h3, 8'h00);
    chk_rd(4'h1, last);
    $display("reset test done");
    wr(4'h0, 8'h07);
    @(posedge ref_clk);
    sleep_req <= 1'b1;
    #1 `CHK("sample_en", 1'b1, sample_en)
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 `CHK("power", 1'b0, analog_power_en)
    `CHK("sample_en", 1'b0, sample_en)
    chk_rd(4'h0, 8'h05);
    chk_rd(4'h2, 8'h02);
    #1 `CHK("power", 1'b0, analog_power_en)
    $display("abort test done");
    results();
  end
endmodule
